// [design/second_tick_gen.sv]
// Compensated second tick generator with AHB-Lite register slave
//
// Functional notes
// [RL1] Offset and temperature ppm corrections held in two separate registers.
// [RL2] Calendar tick corrected in coarse 60 us steps, per tick.
// [RL3] Coarse corrections spread over each minute so 60 ticks sum right.
// [RL4] Fine tick divides the fast clock; one count moves it 1 ppm.
// [RL5] Exact fast counts per second equal nominal minus total ppm error.
// [RL6] Slow domain counts the second; fast clock only the final window.
// [RL7] Slow timer runs free from the crystal clock, up-count with compares.
// [RL8] Fast timer stays off until the slow compare wakes it.
// [RL9] Two slow compares: loop enable, then fast tick placement.
// [RL10] Fast clock enabled several slow cycles before it is relied on.
// [RL11] At enable compare, fast clock on, fast timer captures each slow edge.
// [RL12] At later compare, captured count plus window minus error becomes the tick compare.
// [RL13] After the tick, fast timer and fast clock are switched off.
// [RL14] Tick placement uses a hardware capture taken on the slow edge.
// [RL15] Measurement raises sensor power, samples both voltages, lowers power.
// [RL16] Temperature value accepted only while the ready flag is set.
// [RL17] Fine tick output is a square wave, once per second.
// [RL18] Nominal fast counts per second is a parameter, default one million.
`timescale 1ns/1ps
module second_tick_gen #(
    parameter int NOMINAL = tick_comp_pkg::FAST_NOMINAL, // RL18
    parameter int SETTLE  = tick_comp_pkg::SETTLE_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        slow_clk_pin,
    input  wire logic        fast_clk_pin,
    input  wire logic [9:0]  adc_ref,
    input  wire logic [9:0]  adc_ntc,
    output logic             fll_enable,
    output logic             fine_tick,
    output logic             tick_output_pin,
    output logic             sensor_power,
    output logic             irq
);

    localparam logic [19:0] WINDOW_FAST =
        20'(NOMINAL * tick_comp_pkg::WINDOW_SLOW / tick_comp_pkg::SLOW_HZ);
    localparam logic [14:0] HALF_LOCAL = tick_comp_pkg::HALF_SECOND;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0]            slow_sync_reg;
    logic [2:0]            fast_sync_reg;
    tick_comp_pkg::sense_t adc_s1_reg;
    tick_comp_pkg::sense_t adc_s2_reg;
    logic                  slow_rise;
    logic                  fast_rise;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            slow_sync_reg <= 3'h0;
            fast_sync_reg <= 3'h0;
            adc_s1_reg    <= '0;
            adc_s2_reg    <= '0;
        end
        else
        begin
            slow_sync_reg <= {slow_sync_reg[1:0], slow_clk_pin};
            fast_sync_reg <= {fast_sync_reg[1:0], fast_clk_pin};
            adc_s1_reg    <= '{ntc: adc_ntc, ref_v: adc_ref};
            adc_s2_reg    <= adc_s1_reg;
        end
    end

    assign slow_rise = slow_sync_reg[1] & ~slow_sync_reg[2];
    assign fast_rise = fast_sync_reg[1] & ~fast_sync_reg[2];

    // ------------------------------------------------------------
    // Registers written by software
    // ------------------------------------------------------------
    logic [1:0]          ctrl_reg;
    logic signed [15:0]  offset_cal_reg;
    logic signed [15:0]  temp_comp_reg;
    logic [14:0]         pll_on_cmp_reg;
    logic [14:0]         fast_start_cmp_reg;
    logic [3:0]          int_en_reg;
    logic                temp_comp_ready_flag;
    tick_comp_pkg::bus_req_t req_reg;
    logic                req_valid_reg;
    logic                wr_now;
    logic                sense_start;
    logic                tc_ready_set;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign wr_now    = req_valid_reg & req_reg.wr;
    assign sense_start = wr_now
        & (req_reg.addr == tick_comp_pkg::ADDR_SENSE_CMD) & hwdata[0];

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            req_valid_reg <= 1'b0;
            req_reg       <= '0;
        end
        else if (hready)
        begin
            req_valid_reg <= hsel & htrans[1];
            req_reg       <= '{wr: hwrite, addr: haddr[7:0]};
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_reg           <= tick_comp_pkg::CTRL_RST;
            offset_cal_reg     <= 16'sh0000;
            temp_comp_reg      <= 16'sh0000;
            pll_on_cmp_reg     <= tick_comp_pkg::PLL_ON_RST;
            fast_start_cmp_reg <= tick_comp_pkg::FAST_START_RST;
            int_en_reg         <= 4'h0;
        end
        else if (wr_now)
        begin
            case (req_reg.addr)
                tick_comp_pkg::ADDR_CTRL:
                    ctrl_reg <= hwdata[1:0];
                tick_comp_pkg::ADDR_OFFSET_CAL:
                    offset_cal_reg <= hwdata[15:0]; // RL1
                tick_comp_pkg::ADDR_TEMP_COMP:
                begin
                    if (temp_comp_ready_flag)
                        temp_comp_reg <= hwdata[15:0]; // RL1 RL16
                end
                tick_comp_pkg::ADDR_PLL_ON:
                    pll_on_cmp_reg <= hwdata[14:0]; // RL9
                tick_comp_pkg::ADDR_FAST_START:
                    fast_start_cmp_reg <= hwdata[14:0]; // RL9
                tick_comp_pkg::ADDR_INT_EN:
                    int_en_reg <= hwdata[3:0];
                default:
                    int_en_reg <= int_en_reg;
            endcase
        end
    end

    // Ready drops on an accepted write and returns at the minute mark
    always_ff @(posedge clk)
    begin
        if (rst)
            temp_comp_ready_flag <= 1'b1;
        else if (tc_ready_set)
            temp_comp_ready_flag <= 1'b1;
        else if (wr_now && req_reg.addr == tick_comp_pkg::ADDR_TEMP_COMP)
            temp_comp_ready_flag <= 1'b0; // RL16
    end

    // ------------------------------------------------------------
    // Total error and exact count per second
    // ------------------------------------------------------------
    logic signed [16:0] err_total;
    logic [20:0]        exact_cnt_reg;

    assign err_total = 17'(offset_cal_reg) + 17'(temp_comp_reg); // RL1

    always_ff @(posedge clk)
    begin
        if (rst)
            exact_cnt_reg <= 21'(NOMINAL);
        else
            exact_cnt_reg <= 21'(NOMINAL) - 21'(err_total); // RL5
    end

    // ------------------------------------------------------------
    // Slow timer
    // ------------------------------------------------------------
    logic [14:0] slow_cnt_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
            slow_cnt_reg <= 15'h0000;
        else if (slow_rise)
            slow_cnt_reg <= slow_cnt_reg + 15'h0001; // RL6 RL7
    end

    // ------------------------------------------------------------
    // Fine tick sequence
    // ------------------------------------------------------------
    tick_comp_pkg::fine_state_t fine_state_reg;
    logic [19:0] fast_cnt_reg;
    logic [19:0] fast_capture_reg;
    logic [19:0] fast_tick_compare;
    logic        fine_fire;

    assign fine_fire = (fine_state_reg == tick_comp_pkg::F_CMP)
        && (fast_cnt_reg >= fast_tick_compare);

    always_ff @(posedge clk)
    begin
        if (rst)
            fine_state_reg <= tick_comp_pkg::F_OFF;
        else
        begin
            case (fine_state_reg)
                tick_comp_pkg::F_OFF:
                    if (ctrl_reg[tick_comp_pkg::CTRL_FINE_RUN] && slow_rise
                        && slow_cnt_reg == pll_on_cmp_reg)
                        fine_state_reg <= tick_comp_pkg::F_CAPT; // RL8 RL11
                tick_comp_pkg::F_CAPT:
                    if (slow_rise && slow_cnt_reg == fast_start_cmp_reg)
                        fine_state_reg <= tick_comp_pkg::F_LOAD; // RL10
                tick_comp_pkg::F_LOAD:
                    fine_state_reg <= tick_comp_pkg::F_CMP; // RL12
                tick_comp_pkg::F_CMP:
                    if (fine_fire)
                        fine_state_reg <= tick_comp_pkg::F_OFF; // RL13
                default:
                    fine_state_reg <= tick_comp_pkg::F_OFF;
            endcase
        end
    end

    // Fast clock request held from enable compare until the tick
    assign fll_enable = (fine_state_reg != tick_comp_pkg::F_OFF); // RL10 RL13

    always_ff @(posedge clk)
    begin
        if (rst)
            fast_cnt_reg <= 20'h00000;
        else if (fine_state_reg == tick_comp_pkg::F_OFF)
            fast_cnt_reg <= 20'h00000; // RL8 RL13
        else if (fast_rise)
            fast_cnt_reg <= fast_cnt_reg + 20'h00001; // RL4
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            fast_capture_reg <= 20'h00000;
        else if (fine_state_reg == tick_comp_pkg::F_CAPT && slow_rise)
            fast_capture_reg <= fast_cnt_reg; // RL11 RL14
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            fast_tick_compare <= 20'h00000;
        else if (fine_state_reg == tick_comp_pkg::F_LOAD)
            fast_tick_compare <= fast_capture_reg + WINDOW_FAST
                - 20'(err_total); // RL4 RL12 RL14
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            fine_tick <= 1'b0;
        else if (fine_fire)
            fine_tick <= 1'b1; // RL17
        else if (slow_rise && slow_cnt_reg == HALF_LOCAL)
            fine_tick <= 1'b0; // RL17
    end

    // ------------------------------------------------------------
    // Calendar tick with coarse correction
    // ------------------------------------------------------------
    logic [16:0] cal_cnt_reg;
    logic [5:0]  sec_in_min_reg;
    logic [16:0] err_mag;
    logic [16:0] cal_last;
    logic        cal_wrap;

    always_comb
    begin
        err_mag = err_total[16] ? 17'(-err_total) : 17'(err_total);
        if (err_mag > 17'(tick_comp_pkg::ERR_MAX_STEPS))
            err_mag = 17'(tick_comp_pkg::ERR_MAX_STEPS);
        cal_last = 17'(tick_comp_pkg::SLOW_HZ - 1);
        if (17'(sec_in_min_reg) < err_mag)
        begin
            if (err_total[16])
                cal_last = cal_last - 17'(tick_comp_pkg::STEP_SLOW); // RL2
            else
                cal_last = cal_last + 17'(tick_comp_pkg::STEP_SLOW); // RL2
        end
    end

    assign cal_wrap = slow_rise && (cal_cnt_reg >= cal_last);
    assign tc_ready_set = cal_wrap && (sec_in_min_reg == 6'h3B);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cal_cnt_reg    <= 17'h00000;
            sec_in_min_reg <= 6'h00;
        end
        else if (!ctrl_reg[tick_comp_pkg::CTRL_CAL_RUN])
        begin
            cal_cnt_reg    <= 17'h00000;
            sec_in_min_reg <= 6'h00;
        end
        else if (cal_wrap)
        begin
            cal_cnt_reg    <= 17'h00000;
            sec_in_min_reg <= (sec_in_min_reg == 6'h3B) ? 6'h00
                : sec_in_min_reg + 6'h01; // RL3
        end
        else if (slow_rise)
            cal_cnt_reg <= cal_cnt_reg + 17'h00001;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            tick_output_pin <= 1'b0;
        else
            tick_output_pin <= ctrl_reg[tick_comp_pkg::CTRL_CAL_RUN]
                && (cal_cnt_reg < 17'(HALF_LOCAL)); // RL2
    end

    // ------------------------------------------------------------
    // Sensor sequencer
    // ------------------------------------------------------------
    tick_comp_pkg::sense_t sense_result;
    logic                  sense_done;
    logic                  sense_busy;

    sensor_seq #(
        .SETTLE    (SETTLE)
    ) u_sense (
        .clk       (clk),
        .rst       (rst),
        .start     (sense_start),
        .sample_in (adc_s2_reg),
        .power     (sensor_power),
        .result    (sense_result),
        .done      (sense_done),
        .busy      (sense_busy)
    );

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    logic [3:0] int_stat_reg;
    logic [3:0] int_set;
    logic [3:0] int_clr;

    assign int_set = {tc_ready_set, sense_done, cal_wrap, fine_fire};
    assign int_clr = (wr_now && req_reg.addr == tick_comp_pkg::ADDR_INT_CLR)
        ? hwdata[3:0] : 4'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
            int_stat_reg <= 4'h0;
        else
            int_stat_reg <= (int_stat_reg & ~int_clr) | int_set;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(int_stat_reg & int_en_reg);
    end

    // ------------------------------------------------------------
    // Read data, registered in the address phase
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h00000000;
        case (haddr[7:0])
            tick_comp_pkg::ADDR_CTRL:
                rd_mux = {30'h0, ctrl_reg};
            tick_comp_pkg::ADDR_OFFSET_CAL:
                rd_mux = {16'h0000, offset_cal_reg};
            tick_comp_pkg::ADDR_TEMP_COMP:
                rd_mux = {16'h0000, temp_comp_reg};
            tick_comp_pkg::ADDR_PLL_ON:
                rd_mux = {17'h0, pll_on_cmp_reg};
            tick_comp_pkg::ADDR_FAST_START:
                rd_mux = {17'h0, fast_start_cmp_reg};
            tick_comp_pkg::ADDR_STATUS:
                rd_mux = {26'h0, sense_busy, fll_enable,
                          fine_state_reg, 1'b0, temp_comp_ready_flag};
            tick_comp_pkg::ADDR_CAPTURE:
                rd_mux = {12'h000, fast_capture_reg};
            tick_comp_pkg::ADDR_TICK_CMP:
                rd_mux = {12'h000, fast_tick_compare};
            tick_comp_pkg::ADDR_EXACT:
                rd_mux = {11'h000, exact_cnt_reg};
            tick_comp_pkg::ADDR_SENSE_DATA:
                rd_mux = {6'h00, sense_result.ntc, 6'h00, sense_result.ref_v};
            tick_comp_pkg::ADDR_INT_STAT:
                rd_mux = {28'h0000000, int_stat_reg};
            tick_comp_pkg::ADDR_INT_EN:
                rd_mux = {28'h0000000, int_en_reg};
            default:
                rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            hrdata <= 32'h00000000;
        else if (hready && hsel && htrans[1] && !hwrite)
            hrdata <= rd_mux;
    end

endmodule

// [shared/tick_comp_pkg.sv]
// Shared constants and types for the compensated second tick generator
package tick_comp_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 40;
    localparam int SLOW_HZ         = 32768;
    localparam int SLOW_BITS       = 15;
    localparam int FAST_NOMINAL    = 1000000;
    localparam int WINDOW_SLOW     = 100;
    localparam int STEP_US         = 60;
    localparam int STEP_SLOW       = (STEP_US * SLOW_HZ + 999999) / 1000000;
    localparam int ERR_MAX_STEPS   = 60;
    localparam int SETTLE_NS       = 30000;
    localparam int SETTLE_CYC      =
        (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [14:0] HALF_SECOND = 15'h4000;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL       = 8'h00;
    localparam logic [7:0] ADDR_OFFSET_CAL = 8'h04;
    localparam logic [7:0] ADDR_TEMP_COMP  = 8'h08;
    localparam logic [7:0] ADDR_PLL_ON     = 8'h0C;
    localparam logic [7:0] ADDR_FAST_START = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;
    localparam logic [7:0] ADDR_CAPTURE    = 8'h18;
    localparam logic [7:0] ADDR_TICK_CMP   = 8'h1C;
    localparam logic [7:0] ADDR_EXACT      = 8'h20;
    localparam logic [7:0] ADDR_SENSE_CMD  = 8'h24;
    localparam logic [7:0] ADDR_SENSE_DATA = 8'h28;
    localparam logic [7:0] ADDR_INT_STAT   = 8'h2C;
    localparam logic [7:0] ADDR_INT_EN     = 8'h30;
    localparam logic [7:0] ADDR_INT_CLR    = 8'h34;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_FINE_RUN   = 0;
    localparam int CTRL_CAL_RUN    = 1;
    localparam int IRQ_FINE_TICK   = 0;
    localparam int IRQ_CAL_TICK    = 1;
    localparam int IRQ_SENSE_DONE  = 2;
    localparam int IRQ_TC_READY    = 3;
    localparam int IRQ_BITS        = 4;
    localparam logic [1:0]  CTRL_RST        = 2'h3;
    localparam logic [14:0] PLL_ON_RST      = 15'h7F94;
    localparam logic [14:0] FAST_START_RST  = 15'h7F9C;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [9:0] ntc;
        logic [9:0] ref_v;
    } sense_t;

    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
    } bus_req_t;

    typedef enum logic [1:0] {F_OFF, F_CAPT, F_LOAD, F_CMP} fine_state_t;

endpackage

// [design/sensor_seq.sv]
// Power and sampling sequencer for the NTC divider
`timescale 1ns/1ps
module sensor_seq #(
    parameter int SETTLE = tick_comp_pkg::SETTLE_CYC
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  start,
    input  wire tick_comp_pkg::sense_t sample_in,
    output logic                       power,
    output tick_comp_pkg::sense_t      result,
    output logic                       done,
    output logic                       busy
);

    typedef enum logic [1:0] {S_IDLE, S_REF, S_NTC} seq_state_t;

    seq_state_t  state_reg;
    logic [15:0] wait_reg;

    // ------------------------------------------------------------
    // Sequence: power up, settle, sample reference, sample NTC
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_reg <= S_IDLE;
            wait_reg  <= 16'h0000;
            power     <= 1'b0;
            done      <= 1'b0;
            result    <= '0;
        end
        else
        begin
            done <= 1'b0;
            case (state_reg)
                S_IDLE:
                begin
                    if (start)
                    begin
                        power     <= 1'b1; // RL15
                        wait_reg  <= 16'(SETTLE - 1);
                        state_reg <= S_REF;
                    end
                end
                S_REF:
                begin
                    if (wait_reg == 16'h0000)
                    begin
                        result.ref_v <= sample_in.ref_v; // RL15
                        wait_reg     <= 16'(SETTLE - 1);
                        state_reg    <= S_NTC;
                    end
                    else
                        wait_reg <= wait_reg - 16'h0001;
                end
                S_NTC:
                begin
                    if (wait_reg == 16'h0000)
                    begin
                        result.ntc <= sample_in.ntc; // RL15
                        power      <= 1'b0; // RL15
                        done       <= 1'b1;
                        state_reg  <= S_IDLE;
                    end
                    else
                        wait_reg <= wait_reg - 16'h0001;
                end
                default:
                    state_reg <= S_IDLE;
            endcase
        end
    end

    assign busy = (state_reg != S_IDLE);

endmodule

// [verif/tick_meter_model.sv]
// Tick meter model: crystal and gated fast clock source, tick counter
`timescale 1ns/1ps
module tick_meter_model (
    input  wire logic fll_enable,
    input  wire logic fine_tick,
    output logic      slow_clk_pin,
    output logic      fast_clk_pin,
    output int        n_tick
);
    initial
    begin
        slow_clk_pin = 1'b0;
        fast_clk_pin = 1'b0;
        n_tick = 0;
    end
    // Slow pin runs at 10 bus clocks, fast pin at 414 ns, so a full window fits the run
    always #200 slow_clk_pin = ~slow_clk_pin;
    // Gated clock stands low while the loop is off
    always #207 fast_clk_pin = fll_enable ? ~fast_clk_pin : 1'b0;
    always @(posedge fine_tick) n_tick++;
endmodule

// [verif/second_tick_gen_monitor.sv]
// Port checker for the compensated second tick generator
`timescale 1ns/1ps
module second_tick_gen_monitor #(
    parameter int SETTLE = tick_comp_pkg::SETTLE_CYC
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        fll_enable,
    input wire logic        fine_tick,
    input wire logic        sensor_power
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic [15:0] pw_cnt;
    always_ff @(posedge clk)
        pw_cnt <= (rst || !sensor_power) ? 16'h0 : pw_cnt + 16'h1;
    a_ready_const: assert property (hreadyout) else $error("wait state");
    a_resp_okay: assert property (!hresp) else $error("error response");
    a_rdata_src: assert property ($changed(hrdata) |->
        $past(hsel && htrans[1] && !hwrite && hready))
        else $error("read data moved without read");
    a_fll_settle: assert property ($rose(fll_enable) |=>
        fll_enable[*8]) else $error("fast clock not held");
    a_tick_cause: assert property ($rose(fine_tick) |->
        $past(fll_enable)) else $error("tick without fast clock");
    a_fll_release: assert property ($rose(fine_tick) |->
        ##[0:1] !fll_enable) else $error("fast clock left on");
    a_tick_square: assert property ($rose(fine_tick) |=>
        fine_tick[*8]) else $error("tick too short");
    a_power_span: assert property ($fell(sensor_power) |->
        pw_cnt >= 2 * SETTLE - 1) else $error("sensor power too short");
endmodule
bind second_tick_gen second_tick_gen_monitor #(.SETTLE(SETTLE)) i_mon (
    .clk(clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fll_enable(fll_enable), .fine_tick(fine_tick),
    .sensor_power(sensor_power));

// [verif/tb_second_tick_gen.sv]
// Self-checking bench for the compensated second tick generator
`timescale 1ns/1ps
`define CHK(nm, ex, ac) \
    begin \
        comparisons++; \
        if ((ac) !== (ex)) \
        begin \
            n_fail++; \
            $display("MISMATCH %s exp %0h got %0h", nm, ex, ac); \
        end \
    end
module tb_second_tick_gen;
    localparam int WIN = tick_comp_pkg::FAST_NOMINAL * 100 / 32768;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [9:0]  adc_ref = 10'h2A5;
    logic [9:0]  adc_ntc = 10'h13C;
    logic [31:0] hrdata, rd, cap;
    logic        hready, hreadyout, hresp, slow_clk_pin, fast_clk_pin;
    logic        fll_enable, fine_tick, tick_output_pin, sensor_power, irq;
    int          n_tick;
    int          n_fail = 0;
    int          comparisons = 0;
    assign hready = hreadyout;
    always #20 clk = ~clk;
    second_tick_gen #(.SETTLE(4)) i_dut (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .slow_clk_pin(slow_clk_pin),
        .fast_clk_pin(fast_clk_pin), .adc_ref(adc_ref), .adc_ntc(adc_ntc),
        .fll_enable(fll_enable), .fine_tick(fine_tick), .irq(irq),
        .tick_output_pin(tick_output_pin), .sensor_power(sensor_power));
    tick_meter_model i_meter (.fll_enable(fll_enable), .n_tick(n_tick),
        .fine_tick(fine_tick), .slow_clk_pin(slow_clk_pin),
        .fast_clk_pin(fast_clk_pin));
    // One single transfer, then one idle cycle
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        @(posedge clk);
    endtask
    task automatic test_done;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic t_comp;
        bus(1'b1, tick_comp_pkg::ADDR_OFFSET_CAL, 32'h5);
        bus(1'b1, tick_comp_pkg::ADDR_TEMP_COMP, 32'h3);
        bus(1'b0, tick_comp_pkg::ADDR_EXACT, 32'h0);
        `CHK("exact", 21'(tick_comp_pkg::FAST_NOMINAL - 8), rd[20:0])
        bus(1'b1, tick_comp_pkg::ADDR_TEMP_COMP, 32'h9);
        bus(1'b0, tick_comp_pkg::ADDR_TEMP_COMP, 32'h0);
        `CHK("temp", 16'h3, rd[15:0])
        bus(1'b0, tick_comp_pkg::ADDR_OFFSET_CAL, 32'h0);
        `CHK("offset", 16'h5, rd[15:0])
        bus(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        bus(1'b0, tick_comp_pkg::ADDR_CTRL, 32'h0);
        `CHK("ctrl", tick_comp_pkg::CTRL_RST, rd[1:0])
        `CHK("cal pin", 1'b1, tick_output_pin)
    endtask
    task automatic t_fine;
        for (int i = 0; i < 40000 && fine_tick !== 1'b1; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        `CHK("fll off", 1'b0, fll_enable)
        `CHK("irq fine", 1'b1, irq)
        `CHK("ticks", 1, n_tick)
        bus(1'b0, tick_comp_pkg::ADDR_CAPTURE, 32'h0);
        cap = rd;
        bus(1'b0, tick_comp_pkg::ADDR_TICK_CMP, 32'h0);
        `CHK("tick cmp", cap[20:0] + 21'(WIN - 8), rd[20:0])
        bus(1'b1, tick_comp_pkg::ADDR_INT_CLR, 32'h1);
        repeat (2) @(posedge clk);
        `CHK("irq clr", 1'b0, irq)
    endtask
    task automatic t_sense;
        bus(1'b1, tick_comp_pkg::ADDR_INT_EN, 32'h0);
        bus(1'b1, tick_comp_pkg::ADDR_SENSE_CMD, 32'h1);
        `CHK("power on", 1'b1, sensor_power)
        for (int i = 0; i < 100 && sensor_power !== 1'b0; i++) @(posedge clk);
        repeat (2) @(posedge clk);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b0, tick_comp_pkg::ADDR_SENSE_DATA, 32'h0);
        `CHK("sense", {6'h0, adc_ntc, 6'h0, adc_ref}, rd)
        bus(1'b0, tick_comp_pkg::ADDR_INT_STAT, 32'h0);
        `CHK("stat done", 1'b1, rd[2])
        bus(1'b1, tick_comp_pkg::ADDR_INT_EN, 32'h4);
        @(posedge clk);
        `CHK("irq on", 1'b1, irq)
        bus(1'b1, tick_comp_pkg::ADDR_INT_CLR, 32'h4);
        @(posedge clk);
        `CHK("irq off", 1'b0, irq)
    endtask
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // Pull the fine window early so the run stays short
        bus(1'b1, tick_comp_pkg::ADDR_PLL_ON, 32'h14);
        bus(1'b1, tick_comp_pkg::ADDR_FAST_START, 32'h1C);
        bus(1'b1, tick_comp_pkg::ADDR_INT_EN, 32'h1);
        t_comp();
        t_fine();
        t_sense();
        test_done();
    end
    initial
    begin
        repeat (80000) @(posedge clk);
        n_fail++;
        test_done();
    end
endmodule
